// ---- include/spi_pkg.sv ----
// Shared constants and state types for the serial peripheral controller.
// How it works
// RL1 - Divider 1 shifts one bit per system clock cycle.
// RL2 - Held select, divider 1, idle gap, same slave: slot stays full, word resent.
// RL3 - Software never combines select hold after transfer with divider 1.
// RL4 - Fixed, held, DMA fed: final flag releases select once transmitter drains.
// RL5 - Software keeps select held across DMA transfers with a general purpose pin.
// RL6 - Select config written outside controller mode gives a spurious clock pulse.
// RL7 - Software sets the controller mode bit before writing select configuration.
// RL8 - Fixed mode reports DMA word size from select 0 width, whatever select.
// RL9 - Software sets select 0 width to 8 bits for byte DMA on other selects.
// RL10 - Divider 1 with odd width adds one extra serial clock pulse.
// RL11 - Disable command is ignored while in slave mode.
// RL12 - Software stops slave mode by reading data then issuing software reset.
// RL13 - Polarity 1, phase 0, slow select then divider-1 select: extra pulse.
// RL14 - Mixed divider 1 settings with polarity 1, phase 0 are avoided.
package spi_pkg;
    localparam int CS_NUM       = 4;
    localparam int CS_W         = 2;
    localparam int DIV_W        = 8;
    localparam int BITS_W       = 4;
    localparam int DATA_W       = 16;
    localparam int WORD_W       = 32;
    localparam int CNT_W        = 5;
    localparam int TD_PCS_LSB   = 16;
    localparam int TD_FINAL_BIT = 24;
    localparam logic [CNT_W-1:0] WIDTH_BASE = 5'h08;
    localparam logic [DIV_W-1:0] DIV_ONE    = 8'h01;
    localparam logic [CS_NUM-1:0] CS_N_IDLE = 4'hf;
    localparam int SYNC_W       = 4;
    localparam int SY_SCLK      = 0;
    localparam int SY_MOSI      = 1;
    localparam int SY_MISO      = 2;
    localparam int SY_SS        = 3;

    typedef enum logic [1:0] {ST_IDLE, ST_SPUR, ST_SHIFT, ST_EXTRA} mst_state_t;

    typedef struct packed {
        mst_state_t          state;
        logic                enabled;
        logic [DATA_W-1:0]   holding;
        logic [CS_W-1:0]     hold_cs;
        logic                hold_last;
        logic                hold_full;
        logic [DATA_W-1:0]   shift;
        logic [DATA_W-1:0]   rx_sh;
        logic [DATA_W-1:0]   rx_data;
        logic                rx_ready;
        logic [CNT_W-1:0]    bit_cnt;
        logic [CS_W-1:0]     cur_cs;
        logic                cur_last;
        logic                cs_active;
        logic [CS_NUM-1:0]   cs_n;
        logic                prev_slow;
        logic                extra_pend;
        logic                gap_seen;
        logic                spur_pend;
        logic                samp;
        logic                sclk;
        logic                dma_half;
        logic                sclk_d;
        logic                ss_d;
    } ctl_t;

    localparam ctl_t CTL_RST = '{state: ST_IDLE, cs_n: CS_N_IDLE, ss_d: 1'b1, default: '0};
endpackage

// ---- include/bit_timer_if.sv ----
// Link between the controller and its bit timer.
interface bit_timer_if;
    import spi_pkg::*;
    logic             run;
    logic [DIV_W-1:0] divider;
    logic             lead;
    logic             trail;
    logic             tend;

    modport timer (input run, input divider, output lead, output trail, output tend);
    modport user  (output run, output divider, input lead, input trail, input tend);
endinterface

// ---- hdl/bit_timer.sv ----
// Bit period timer giving leading, trailing and end-of-bit enables.
module bit_timer
    import spi_pkg::*;
(
    input  wire logic  clk_sys_i,
    input  wire logic  nrst_i,
    bit_timer_if.timer tif
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic [DIV_W-1:0] div_eff;

    // Zero divider is treated as one so the timer can never stall
    assign div_eff = (tif.divider == '0) ? DIV_ONE : tif.divider;

    // Divider 1 puts all three enables in the same cycle
    assign tif.lead  = tif.run && (cnt_r == '0); // [RL1]
    assign tif.trail = tif.run && (cnt_r == (div_eff >> 1));
    assign tif.tend  = tif.run && (cnt_r == div_eff - DIV_ONE);

    // Count restarts at zero whenever the timer is idle
    always_comb begin
        cnt_nxt = '0;
        if (tif.run && !tif.tend) begin
            cnt_nxt = cnt_r + DIV_ONE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ---- hdl/spi_ctrl.sv ----
// Serial peripheral controller, controller and slave modes, with its known quirks.
module spi_ctrl
    import spi_pkg::*;
(
    input  wire logic                      clk_sys_i,
    input  wire logic                      nrst_i,
    input  wire logic                      enable_i,
    input  wire logic                      disable_i,
    input  wire logic                      soft_reset_i,
    input  wire logic                      controller_mode_bit_i,
    input  wire logic                      fixed_select_i,
    input  wire logic [CS_W-1:0]           fixed_cs_i,
    input  wire logic                      cpol_i,
    input  wire logic [CS_NUM-1:0]         cs_hold_after_transfer_i,
    input  wire logic [CS_NUM-1:0]         clock_phase_inverted_i,
    input  wire logic [CS_NUM*DIV_W-1:0]   serial_clock_divider_i,
    input  wire logic [CS_NUM*BITS_W-1:0]  bits_code_i,
    input  wire logic                      cs_config_write_i,
    input  wire logic [WORD_W-1:0]         transmit_data_reg_i,
    input  wire logic                      tx_write_i,
    output logic                           tx_slot_free_o,
    output logic                           transmit_drained_o,
    output logic [DATA_W-1:0]              rx_data_o,
    output logic                           rx_ready_o,
    input  wire logic                      rx_read_i,
    output logic                           dma_halfword_o,
    output logic                           enabled_o,
    output logic                           serial_clock_out_o,
    output logic                           sclk_oe_n_o,
    input  wire logic                      sclk_i,
    output logic                           mosi_o,
    output logic                           mosi_oe_n_o,
    input  wire logic                      mosi_i,
    output logic                           miso_o,
    output logic                           miso_oe_n_o,
    input  wire logic                      miso_i,
    output logic [CS_NUM-1:0]              cs_n_o,
    input  wire logic                      ss_n_i
);
    bit_timer_if tif ();

    ctl_t              st_r;
    ctl_t              st_nxt;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              master;
    logic              slave;
    logic [CS_W-1:0]   run_cs;
    logic [CNT_W-1:0]  cur_width;
    logic              cur_div1;
    logic              s_sclk;
    logic              s_ss_n;
    logic              lead_e;
    logic              trail_e;
    logic              slv_samp;
    logic              slv_drive;
    logic              ss_fall;

    function automatic logic [DIV_W-1:0] div_of(input logic [CS_W-1:0] cs);
        div_of = serial_clock_divider_i[cs*DIV_W +: DIV_W];
    endfunction

    function automatic logic [CNT_W-1:0] width_of(input logic [CS_W-1:0] cs);
        width_of = WIDTH_BASE + {1'b0, bits_code_i[cs*BITS_W +: BITS_W]};
    endfunction

    // Pins from the outside pass two flops before any logic reads them
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // Select input resets to its idle high level so no false fall follows reset
            sync1_r <= SYNC_W'(1) << SY_SS;
            sync2_r <= SYNC_W'(1) << SY_SS;
        end else begin
            sync1_r <= {ss_n_i, miso_i, mosi_i, sclk_i};
            sync2_r <= sync1_r;
        end
    end

    bit_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .tif       (tif)
    );

    assign master    = st_r.enabled && controller_mode_bit_i;
    assign slave     = st_r.enabled && !controller_mode_bit_i;
    assign run_cs    = (st_r.state == ST_SPUR) ? '0 : st_r.cur_cs;
    assign cur_width = width_of(st_r.cur_cs);
    assign cur_div1  = (div_of(st_r.cur_cs) == DIV_ONE);
    assign tif.run     = master && (st_r.state != ST_IDLE);
    assign tif.divider = div_of(run_cs);

    // Slave edge decode on the second synchroniser stage only
    assign s_sclk    = sync2_r[SY_SCLK];
    assign s_ss_n    = sync2_r[SY_SS];
    assign lead_e    = (s_sclk != st_r.sclk_d) && (s_sclk != cpol_i);
    assign trail_e   = (s_sclk != st_r.sclk_d) && (s_sclk == cpol_i);
    assign slv_samp  = slave && !s_ss_n && (clock_phase_inverted_i[0] ? lead_e : trail_e);
    assign slv_drive = slave && !s_ss_n && (clock_phase_inverted_i[0] ? trail_e : lead_e);
    assign ss_fall   = slave && st_r.ss_d && !s_ss_n;

    // Next state of the whole controller
    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_d = s_sclk;
        st_nxt.ss_d   = s_ss_n;
        if (enable_i) begin
            st_nxt.enabled = 1'b1;
        end
        // Slave mode cannot be left by a disable, only by software reset
        if (disable_i && controller_mode_bit_i) begin // [RL11]
            st_nxt.enabled = 1'b0;
        end
        // A select configuration written before controller mode leaves a pulse pending
        if (cs_config_write_i && !controller_mode_bit_i) begin // [RL6]
            st_nxt.spur_pend = 1'b1;
        end
        if (tx_write_i && tx_slot_free_o) begin
            st_nxt.holding   = transmit_data_reg_i[DATA_W-1:0];
            st_nxt.hold_cs   = fixed_select_i ? fixed_cs_i
                                              : transmit_data_reg_i[TD_PCS_LSB +: CS_W];
            st_nxt.hold_last = transmit_data_reg_i[TD_FINAL_BIT];
            st_nxt.hold_full = 1'b1;
        end
        if (rx_read_i) begin
            st_nxt.rx_ready = 1'b0;
        end
        case (st_r.state)
            ST_IDLE: begin
                st_nxt.sclk = cpol_i;
                if (master && st_r.spur_pend) begin
                    st_nxt.spur_pend = 1'b0;
                    st_nxt.state     = ST_SPUR; // [RL6]
                end else if (master && st_r.hold_full) begin
                    // Divider 1 with held select after an idle gap loses the slot release
                    st_nxt.hold_full  = cs_hold_after_transfer_i[st_r.hold_cs]
                                        && (div_of(st_r.hold_cs) == DIV_ONE)
                                        && st_r.gap_seen && st_r.cs_active
                                        && (st_r.cur_cs == st_r.hold_cs); // [RL2]
                    st_nxt.shift      = st_r.holding << (CNT_W'(DATA_W) - width_of(st_r.hold_cs));
                    st_nxt.cur_cs     = st_r.hold_cs;
                    st_nxt.cur_last   = st_r.hold_last;
                    st_nxt.bit_cnt    = '0;
                    st_nxt.rx_sh      = '0;
                    st_nxt.cs_active  = 1'b1;
                    st_nxt.gap_seen   = 1'b0;
                    st_nxt.extra_pend = cpol_i && !clock_phase_inverted_i[st_r.hold_cs]
                                        && (div_of(st_r.hold_cs) == DIV_ONE)
                                        && st_r.prev_slow; // [RL13] [RL14]
                    st_nxt.state      = ST_SHIFT;
                end else if (master && st_r.cs_active) begin
                    // Final flag drops the select as soon as the transmitter is drained
                    if (st_r.cur_last) begin // [RL4]
                        st_nxt.cs_active = 1'b0;
                    end
                    st_nxt.gap_seen = 1'b1;
                end
            end
            ST_SPUR, ST_EXTRA: begin
                st_nxt.sclk = st_r.sclk ^ (tif.lead | tif.trail);
                // Divider 1 moves one edge a period, so a pulse from idle needs two periods
                if (tif.tend && !(tif.lead && (st_nxt.sclk != cpol_i))) begin
                    st_nxt.sclk  = cpol_i;
                    st_nxt.state = ST_IDLE;
                end
            end
            ST_SHIFT: begin
                // Divider 1 toggles once per bit: the clock follows the system rate
                st_nxt.sclk = st_r.sclk ^ (tif.lead | tif.trail); // [RL1]
                if (clock_phase_inverted_i[st_r.cur_cs] ? tif.lead : tif.trail) begin
                    st_nxt.samp = sync2_r[SY_MISO];
                end
                if (tif.tend) begin
                    st_nxt.shift   = {st_r.shift[DATA_W-2:0], 1'b0};
                    st_nxt.rx_sh   = {st_r.rx_sh[DATA_W-2:0], st_nxt.samp};
                    st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
                    if (st_r.bit_cnt == cur_width - 1'b1) begin
                        st_nxt.rx_data   = st_nxt.rx_sh;
                        st_nxt.rx_ready  = 1'b1;
                        st_nxt.prev_slow = !cur_div1;
                        if (!cs_hold_after_transfer_i[st_r.cur_cs]) begin
                            st_nxt.cs_active = 1'b0;
                        end
                        // Odd widths at divider 1 end with one surplus pulse
                        if ((cur_div1 && cur_width[0]) || st_r.extra_pend) begin // [RL10] [RL13]
                            st_nxt.state = ST_EXTRA;
                        end else begin
                            st_nxt.state = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
        // Slave side: load on select fall, sample and shift on the decoded edges
        if (ss_fall) begin
            st_nxt.bit_cnt   = '0;
            st_nxt.shift     = st_r.hold_full ? st_r.holding << (CNT_W'(DATA_W) - width_of('0))
                                              : '0;
            // A word written in this very cycle stays queued rather than lost
            if (st_r.hold_full) begin
                st_nxt.hold_full = 1'b0;
            end
        end
        if (slv_drive && st_r.bit_cnt != '0) begin
            st_nxt.shift = {st_r.shift[DATA_W-2:0], 1'b0};
        end
        if (slv_samp) begin
            st_nxt.rx_sh   = {st_r.rx_sh[DATA_W-2:0], sync2_r[SY_MOSI]};
            st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
            if (st_r.bit_cnt == width_of('0) - 1'b1) begin
                st_nxt.rx_data  = {st_r.rx_sh[DATA_W-2:0], sync2_r[SY_MOSI]};
                st_nxt.rx_ready = 1'b1;
                st_nxt.bit_cnt  = '0;
            end
        end
        if (slave && s_ss_n) begin
            st_nxt.bit_cnt = '0;
        end
        // Word size seen by DMA: fixed mode always consults select 0
        st_nxt.dma_half = fixed_select_i ? (width_of('0) > WIDTH_BASE) // [RL8]
                                         : (width_of(st_nxt.hold_cs) > WIDTH_BASE);
        st_nxt.cs_n = st_nxt.cs_active ? ~(CS_NUM'(1) << st_nxt.cur_cs) : CS_N_IDLE;
        // Software reset is the only way out of slave mode
        if (soft_reset_i) begin // [RL12]
            st_nxt = CTL_RST;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= CTL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Handshakes are decoded from registers; pins are steered by the mode
    assign tx_slot_free_o     = st_r.enabled && !st_r.hold_full;
    assign transmit_drained_o = st_r.enabled && !st_r.hold_full && (st_r.state == ST_IDLE);
    assign rx_data_o          = st_r.rx_data;
    assign rx_ready_o         = st_r.rx_ready;
    assign dma_halfword_o     = st_r.dma_half;
    assign enabled_o          = st_r.enabled;
    assign serial_clock_out_o = st_r.sclk;
    assign sclk_oe_n_o        = !master;
    assign mosi_o             = st_r.shift[DATA_W-1];
    assign mosi_oe_n_o        = !master;
    assign miso_o             = st_r.shift[DATA_W-1];
    assign miso_oe_n_o        = !(slave && !s_ss_n);
    assign cs_n_o             = st_r.cs_n;
endmodule

// ---- verification/spi_ctrl_assertions.sv ----
// Concurrent port checks for the serial peripheral controller.
module spi_ctrl_assertions
    import spi_pkg::*;
(
    input wire logic                     clk_sys_i,
    input wire logic                     nrst_i,
    input wire logic                     enable_i,
    input wire logic                     disable_i,
    input wire logic                     soft_reset_i,
    input wire logic                     controller_mode_bit_i,
    input wire logic                     fixed_select_i,
    input wire logic                     cpol_i,
    input wire logic [CS_NUM*BITS_W-1:0] bits_code_i,
    input wire logic                     tx_write_i,
    input wire logic                     rx_read_i,
    input wire logic                     tx_slot_free_o,
    input wire logic                     transmit_drained_o,
    input wire logic                     rx_ready_o,
    input wire logic                     dma_halfword_o,
    input wire logic                     enabled_o,
    input wire logic                     serial_clock_out_o,
    input wire logic                     sclk_oe_n_o,
    input wire logic [CS_NUM-1:0]        cs_n_o
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    property p_slave_keep; disable_i && !controller_mode_bit_i && enabled_o && !soft_reset_i
        |=> enabled_o; endproperty
    a_slave_keep: assert property (p_slave_keep) else $error("slave disabled");
    property p_ctl_off; disable_i && controller_mode_bit_i && !enable_i && !soft_reset_i
        |=> !enabled_o; endproperty
    a_ctl_off: assert property (p_ctl_off) else $error("disable ignored");
    property p_sreset; soft_reset_i |=> !enabled_o && !rx_ready_o && cs_n_o == CS_N_IDLE;
    endproperty
    a_sreset: assert property (p_sreset) else $error("soft reset incomplete");
    property p_rx_hold; rx_ready_o && !rx_read_i && !soft_reset_i |=> rx_ready_o; endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive ready lost");
    property p_dma; fixed_select_i && enabled_o && $past(enabled_o) && $stable(bits_code_i)
        && $stable(fixed_select_i) && !$past(soft_reset_i)
        |-> dma_halfword_o == (bits_code_i[BITS_W-1:0] != 4'h0); endproperty
    a_dma: assert property (p_dma) else $error("word size not from select 0");
    property p_take; tx_write_i && tx_slot_free_o && !soft_reset_i |=> !tx_slot_free_o;
    endproperty
    a_take: assert property (p_take) else $error("slot still free");
    property p_drained; transmit_drained_o |-> tx_slot_free_o && enabled_o; endproperty
    a_drained: assert property (p_drained) else $error("drained with word pending");
    property p_idle; transmit_drained_o && $past(transmit_drained_o) && controller_mode_bit_i
        && $stable(cpol_i) |-> serial_clock_out_o == cpol_i; endproperty
    a_idle: assert property (p_idle) else $error("clock off idle level");
    property p_drive; sclk_oe_n_o == !(controller_mode_bit_i && enabled_o); endproperty
    a_drive: assert property (p_drive) else $error("clock drive wrong");
endmodule

bind spi_ctrl spi_ctrl_assertions u_chk (
    .clk_sys_i, .nrst_i, .enable_i, .disable_i, .soft_reset_i, .controller_mode_bit_i,
    .fixed_select_i, .cpol_i, .bits_code_i, .tx_write_i, .rx_read_i, .tx_slot_free_o,
    .transmit_drained_o, .rx_ready_o, .dma_halfword_o, .enabled_o, .serial_clock_out_o,
    .sclk_oe_n_o, .cs_n_o
);

// ---- verification/spi_slave_model.sv ----
// Serial slave model: echoes received bits on miso and counts clock edges.
module spi_slave_model
    import spi_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              sclk_i,
    input  wire logic              mosi_i,
    input  wire logic [CS_NUM-1:0] cs_n_i,
    input  wire logic              clr_i,
    output logic                   miso_o,
    output logic [7:0]             edges_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic              prev = 1'b0;
    logic [DATA_W-1:0] echo = 16'h0000;
    initial miso_o = 1'b0;
    initial edges_o = 8'h00;
    // Every change of the serial clock is one edge
    always @(posedge clk_sys_i) begin
        prev <= sclk_i;
        if (clr_i) begin
            edges_o <= 8'h00;
        end else if (sclk_i != prev) begin
            edges_o <= edges_o + 8'h01;
        end
        // Deselected, the line wanders so a stale bit is never mistaken for data
        if (cs_n_i == CS_N_IDLE) begin
            miso_o <= ~miso_o;
        end else if (sclk_i != prev) begin
            echo   <= {echo[DATA_W-2:0], mosi_i};
            miso_o <= echo[DATA_W-1];
        end
    end
endmodule

// ---- verification/tb.sv ----
// Directed bench for the serial peripheral controller.
module tb
    import spi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, enable_i = 1'b0, disable_i = 1'b0, clr = 1'b0;
    logic soft_reset_i = 1'b0, controller_mode_bit_i = 1'b0, fixed_select_i = 1'b0;
    logic cpol_i = 1'b0, cs_config_write_i = 1'b0, tx_write_i = 1'b0, rx_read_i = 1'b0;
    logic sclk_i = 1'b0, mosi_i = 1'b0, ss_n_i = 1'b1, miso;
    logic [CS_W-1:0]          fixed_cs_i = 2'h0;
    logic [CS_NUM-1:0]        cs_hold_after_transfer_i = 4'h0, clock_phase_inverted_i = 4'h0;
    logic [CS_NUM*DIV_W-1:0]  serial_clock_divider_i = 32'h02020201;
    logic [CS_NUM*BITS_W-1:0] bits_code_i = 16'h0000;
    logic [WORD_W-1:0]        transmit_data_reg_i = 32'h00000000;
    logic tx_slot_free_o, transmit_drained_o, rx_ready_o, dma_halfword_o, enabled_o;
    logic serial_clock_out_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o, miso_oe_n_o;
    logic [CS_NUM-1:0]        cs_n_o;
    logic [DATA_W-1:0]        rx_data;
    logic [7:0]               edges, n;
    int                       fails = 0, check_count = 0, cycles = 0;

    spi_ctrl u_dut (.clk_sys_i, .nrst_i, .enable_i, .disable_i, .soft_reset_i,
        .controller_mode_bit_i, .fixed_select_i, .fixed_cs_i, .cpol_i, .cs_hold_after_transfer_i,
        .clock_phase_inverted_i, .serial_clock_divider_i, .bits_code_i, .cs_config_write_i,
        .transmit_data_reg_i, .tx_write_i, .tx_slot_free_o, .transmit_drained_o,
        .rx_data_o(rx_data),
        .rx_ready_o, .rx_read_i, .dma_halfword_o, .enabled_o, .serial_clock_out_o, .sclk_oe_n_o,
        .sclk_i, .mosi_o, .mosi_oe_n_o, .mosi_i, .miso_o(), .miso_oe_n_o, .miso_i(miso), .cs_n_o,
        .ss_n_i);
    spi_slave_model u_slave (.clk_sys_i, .sclk_i(serial_clock_out_o), .mosi_i(mosi_o),
        .cs_n_i(cs_n_o), .clr_i(clr), .miso_o(miso), .edges_o(edges));

    always #5 clk_sys_i = ~clk_sys_i;

    // Inputs move 1 ns after the edge so the design never races the bench
    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task automatic done(input string what);
        $display("test %s done", what);
    endtask
    task automatic results();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One word: wait for a free slot, write, wait until drained, keep the edge count
    task automatic word(input logic [15:0] d, input logic [1:0] cs, input logic fin);
        int i;
        clr = 1'b1;
        for (i = 0; i < 200 && tx_slot_free_o !== 1'b1; i++) tick();
        chk(32'(tx_slot_free_o), 32'd1, "slot free");
        transmit_data_reg_i = {7'h00, fin, 6'h00, cs, d};
        tx_write_i = 1'b1;
        tick();
        tx_write_i = 1'b0;
        clr = 1'b0;
        for (i = 0; i < 400 && transmit_drained_o !== 1'b1; i++) tick();
        chk(32'(transmit_drained_o), 32'd1, "drained");
        repeat (4) tick();
        n = edges;
    endtask

    // A hang ends the run through the same report
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("FAIL %0t timeout", $time);
            results();
        end
    end

    initial begin
        repeat (2) tick();
        nrst_i = 1'b1;
        tick();
        // Select config written before controller mode: clock moves with no word
        clr = 1'b1;
        pulse(cs_config_write_i);
        clr = 1'b0;
        controller_mode_bit_i = 1'b1;
        pulse(enable_i);
        repeat (6) tick();
        chk(32'(edges != 8'h00), 32'd1, "spurious clock");
        clr = 1'b1;
        pulse(cs_config_write_i);
        clr = 1'b0;
        repeat (6) tick();
        chk(32'(edges), 32'd0, "no clock after mode set");
        chk(32'(mosi_oe_n_o), 32'd0, "controller drives data");
        done("config order");
        // Widths 8 to 16 on the divider 1 select; odd widths carry one extra edge
        for (int c = 0; c <= 8; c++) begin
            bits_code_i[3:0] = c[3:0];
            word(16'ha5c3, 2'h0, 1'b0);
            chk(32'(n), 32'(8 + c + c % 2), "divider 1 edges");
        end
        bits_code_i = 16'h0000;
        word(16'h3c5a, 2'h1, 1'b0);
        chk(32'(n), 32'd16, "divider 2 edges");
        chk(32'(rx_ready_o), 32'd1, "receive ready");
        pulse(rx_read_i);
        chk(32'(rx_ready_o), 32'd0, "receive cleared");
        done("widths");
        // Polarity 1: slow select then fast one at phase 0, again with select 0 phase inverted, then all at divider 1
        cpol_i = 1'b1;
        word(16'h00ff, 2'h1, 1'b0);
        word(16'h00ff, 2'h0, 1'b0);
        chk(32'(n > 8'h08), 32'd1, "slow then fast extra edge");
        clock_phase_inverted_i = 4'h1;
        word(16'h00ff, 2'h1, 1'b0);
        word(16'h00ff, 2'h0, 1'b0);
        chk(32'(n), 32'd8, "inverted phase no extra");
        clock_phase_inverted_i = 4'h0;
        serial_clock_divider_i = 32'h01010101;
        word(16'h00ff, 2'h1, 1'b0);
        word(16'h00ff, 2'h0, 1'b0);
        chk(32'(n), 32'd8, "uniform divider 1");
        cpol_i = 1'b0;
        serial_clock_divider_i = 32'h02020201;
        done("mixed dividers");
        // Held fixed select on a divider 2 select, never with divider 1
        fixed_select_i = 1'b1;
        fixed_cs_i = 2'h1;
        cs_hold_after_transfer_i = 4'h2;
        bits_code_i = 16'h0002;
        word(16'h1234, 2'h0, 1'b0);
        chk(32'(cs_n_o), 32'hd, "select held");
        chk(32'(dma_halfword_o), 32'd1, "size from select 0");
        bits_code_i = 16'h0000;
        word(16'h5678, 2'h0, 1'b1);
        chk(32'(cs_n_o), 32'hf, "final flag release");
        chk(32'(dma_halfword_o), 32'd0, "byte size");
        fixed_select_i = 1'b0;
        cs_hold_after_transfer_i = 4'h0;
        done("held select");
        // Disable works in controller mode only; slave stops by reset
        pulse(disable_i);
        chk(32'(enabled_o), 32'd0, "controller disable");
        controller_mode_bit_i = 1'b0;
        pulse(enable_i);
        pulse(disable_i);
        chk(32'(enabled_o), 32'd1, "slave ignores disable");
        chk(32'(miso_oe_n_o), 32'd1, "deselected slave quiet");
        chk(32'(sclk_oe_n_o), 32'd1, "slave leaves clock");
        chk(32'(mosi_oe_n_o), 32'd1, "slave leaves data out");
        pulse(rx_read_i);
        pulse(soft_reset_i);
        chk(32'(enabled_o), 32'd0, "soft reset stops");
        chk(32'(rx_data), 32'd0, "receive word cleared");
        done("slave stop");
        results();
    end
endmodule
